/* File: inc/uds_regs.svh */
`ifndef UDS_REGS_SVH
`define UDS_REGS_SVH
// Register indices; the byte address is four times the index.
`define UDS_IDX_STA 10'h0c0
`define UDS_IDX_CTB 10'h0c1
`define UDS_IDX_CTC 10'h0c2
`define UDS_IDX_BDL 10'h0c4
`define UDS_IDX_BDH 10'h0c5
`define UDS_IDX_DAT 10'h0c6
// Reset values.
`define UDS_STA_RST 8'h20
`define UDS_CTB_RST 8'h00
`define UDS_CTC_RST 8'h06
// Status A bit positions.
`define UDS_B_RXC  7
`define UDS_B_TXC  6
`define UDS_B_BUFFER_EMPTY_FLAG 5
`define UDS_B_FE   4
`define UDS_B_DOR  3
`define UDS_B_UPE  2
`define UDS_B_U2X  1
`define UDS_B_MULTIPROCESSOR_FILTER_BIT 0
// Control B bit positions.
`define UDS_B_RXCIE 7
`define UDS_B_TXCIE 6
`define UDS_B_BUFFER_EMPTY_IRQ_ENABLE 5
`define UDS_B_RXEN  4
`define UDS_B_TXEN  3
`define UDS_B_CSZ2  2
`define UDS_B_RX9   1
`define UDS_B_TX9   0
// Control C fields.
`define UDS_C_MODE  7:6
`define UDS_C_PEN   5
`define UDS_C_PODD  4
`define UDS_C_STOP2 3
`define UDS_C_CSZ   2:1
`define UDS_MODE_ASYNC 2'b00
`define UDS_MODE_SPI   2'b11
// Oversampling ticks per bit.
`define UDS_OS_NORM 5'd16
`define UDS_OS_FAST 5'd8
`endif

/* File: inc/uds_pkg.sv */
`default_nettype none
package uds_pkg;
	localparam int UDS_RX_DEPTH = 2;
	localparam int UDS_PW       = $clog2(UDS_RX_DEPTH);

	typedef enum logic [1:0] {
		UDS_R_IDLE  = 2'b00,
		UDS_R_START = 2'b01,
		UDS_R_BITS  = 2'b10,
		UDS_R_STOP  = 2'b11
	} uds_rx_e;

	// One received character with the status it arrived with.
	typedef struct packed {
		logic [8:0] data;
		logic       fe;
		logic       pe;
		logic       overrun_flag;
	} uds_entry_s;

	typedef struct packed {
		logic                          ack;
		logic [31:0]                   rdat;
		logic [7:0]                    ctb;
		logic [7:0]                    ctc;
		logic [11:0]                   baud;
		logic                          u2x;
		logic                          multiprocessor_filter_bit;
		logic [11:0]                   bcnt;
		logic                          thr_full;
		logic [8:0]                    thr;
		logic                          tx_busy;
		logic [12:0]                   tsr;
		logic [3:0]                    tbits;
		logic [4:0]                    tcnt;
		logic                          txd;
		logic                          transmit_complete_flag;
		uds_rx_e                       rxs;
		logic [4:0]                    rcnt;
		logic [3:0]                    rbit;
		logic [8:0]                    rsh;
		logic                          rpar;
		logic                          pend;
		uds_entry_s                    pent;
		uds_entry_s [UDS_RX_DEPTH-1:0] fifo;
		logic [UDS_PW-1:0]             wp;
		logic [UDS_PW-1:0]             rp;
		logic [UDS_PW:0]               cnt;
		logic                          s1;
		logic                          s2;
		logic                          rxc_q;
		logic                          txc_q;
		logic                          buffer_empty_flag_q;
	} uds_state_s;
endpackage : uds_pkg
`default_nettype wire

/* File: design/uds_top.sv */
// The implementer's own choice: the Wishbone slave port.
`include "uds_regs.svh"
`default_nettype none
module uds_top #(
	parameter int RX_DEPTH = uds_pkg::UDS_RX_DEPTH
) (
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave.
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [11:0] adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Serial line.
	input  wire logic        rxd_i,
	output logic             txd_o,
	// Interrupt requests.
	input  wire logic        global_ie_i,
	input  wire logic        txc_served_i,
	output logic             rxc_req_o,
	output logic             txc_req_o,
	output logic             buffer_empty_flag_req_o
);
	localparam int PW = uds_pkg::UDS_PW;
	localparam logic [PW:0] DEPTH_C = (PW+1)'(RX_DEPTH);

	// The state struct is sized by the package, so the depth must agree.
	if (RX_DEPTH != uds_pkg::UDS_RX_DEPTH || RX_DEPTH != (1 << PW)) begin : g_chk
		$error("RX_DEPTH must match the package depth and be a power of two");
	end

	uds_pkg::uds_state_s st;
	uds_pkg::uds_state_s n;
	uds_pkg::uds_entry_s head;
	uds_pkg::uds_entry_s ent;
	logic                req;
	logic                wr0;
	logic                rd;
	logic [9:0]          idx;
	logic [3:0]          nb;
	logic [4:0]          os;
	logic [4:0]          half;
	logic                tick;
	logic                pen;
	logic                podd;
	logic                stop2;

	// ********************************
	// Helpers
	// ********************************

	// Character length in data bits; reserved codes fall back to eight.
	function automatic logic [3:0] uds_nbits(input logic [2:0] c);
		case (c)
			3'h0: return 4'h5;
			3'h1: return 4'h6;
			3'h2: return 4'h7;
			3'h7: return 4'h9;
			default: return 4'h8;
		endcase
	endfunction : uds_nbits

	// Serial frame, first bit in bit 0; unused top bits stay as stop level.
	function automatic logic [12:0] uds_frame(input logic [8:0] d, input logic [3:0] nbit,
		input logic pe, input logic po);
		logic [12:0] f;
		logic        p;
		f = '1;
		p = po;
		f[0] = 1'b0;
		for (int i = 0; i < 9; i++) begin
			if (i < int'(nbit)) begin
				f[i+1] = d[i];
				p = p ^ d[i];
			end
		end
		if (pe) begin
			f[nbit+4'h1] = p;
		end
		return f;
	endfunction : uds_frame

	// Status A as software reads it.
	function automatic logic [7:0] uds_sta(input uds_pkg::uds_state_s s,
		input uds_pkg::uds_entry_s h);
		logic [7:0] v;
		logic       spi;
		logic       any;
		v = '0;
		spi = s.ctc[`UDS_C_MODE] == `UDS_MODE_SPI;
		any = s.cnt != '0;
		v[`UDS_B_RXC] = any;
		v[`UDS_B_TXC] = s.transmit_complete_flag;
		v[`UDS_B_BUFFER_EMPTY_FLAG] = ~s.thr_full;
		v[`UDS_B_FE] = h.fe & any & ~spi;
		v[`UDS_B_DOR] = h.overrun_flag & any & ~spi;
		v[`UDS_B_UPE] = h.pe & any;
		v[`UDS_B_U2X] = s.u2x;
		v[`UDS_B_MULTIPROCESSOR_FILTER_BIT] = s.multiprocessor_filter_bit;
		return v;
	endfunction : uds_sta

	// ********************************
	// Decode
	// ********************************

	// Bus request and frame format derived from the control registers.
	assign req   = cyc_i & stb_i & ~st.ack;
	assign wr0   = req & we_i & sel_i[0];
	assign rd    = req & ~we_i;
	assign idx   = adr_i[11:2];
	assign head  = st.fifo[st.rp];
	assign nb    = uds_nbits({st.ctb[`UDS_B_CSZ2], st.ctc[`UDS_C_CSZ]});
	assign pen   = st.ctc[`UDS_C_PEN];
	assign podd  = st.ctc[`UDS_C_PODD];
	assign stop2 = st.ctc[`UDS_C_STOP2];
	assign os    = (st.u2x && st.ctc[`UDS_C_MODE] == `UDS_MODE_ASYNC) ?
		`UDS_OS_FAST : `UDS_OS_NORM;
	assign half  = {1'b0, os[4:1]};
	assign tick  = st.bcnt == '0;

	// ********************************
	// Next state
	// ********************************

	// All behaviour is computed here; the flop process only registers it.
	always_comb begin
		n = st;
		ent = '0;
		n.ack = req;
		n.s1 = rxd_i;
		n.s2 = st.s1;
		n.bcnt = tick ? st.baud : st.bcnt - 12'h001;
		n.rdat = '0;
		if (rd) begin
			case (idx)
				`UDS_IDX_STA: n.rdat[7:0] = uds_sta(st, head);
				`UDS_IDX_CTB: begin
					n.rdat[7:0] = st.ctb;
					n.rdat[`UDS_B_RX9] = head.data[8];
				end
				`UDS_IDX_CTC: n.rdat[7:0] = st.ctc;
				`UDS_IDX_BDL: n.rdat[7:0] = st.baud[7:0];
				`UDS_IDX_BDH: n.rdat[3:0] = st.baud[11:8];
				`UDS_IDX_DAT: n.rdat[7:0] = head.data[7:0];
				default: n.rdat = '0;
			endcase
		end
		// A read of the data location pops when the queue is not empty, so error flags move on too.
		if (rd && idx == `UDS_IDX_DAT && st.cnt != '0) begin
			n.rp = st.rp + 1'b1;
			n.cnt = st.cnt - 1'b1;
		end
		if (wr0) begin
			case (idx)
				`UDS_IDX_STA: begin
					if (dat_i[`UDS_B_TXC]) begin
						n.transmit_complete_flag = 1'b0;
					end
					n.u2x = dat_i[`UDS_B_U2X];
					n.multiprocessor_filter_bit = dat_i[`UDS_B_MULTIPROCESSOR_FILTER_BIT];
				end
				`UDS_IDX_CTB: begin
					n.ctb = dat_i[7:0];
					n.ctb[`UDS_B_RX9] = 1'b0;
				end
				`UDS_IDX_CTC: n.ctc = dat_i[7:0];
				`UDS_IDX_BDL: n.baud[7:0] = dat_i[7:0];
				`UDS_IDX_BDH: n.baud[11:8] = dat_i[3:0];
				`UDS_IDX_DAT: begin
					if (!st.thr_full) begin
						n.thr = {st.ctb[`UDS_B_TX9], dat_i[7:0]} &
							~(9'h1ff << nb);
						n.thr_full = 1'b1;
					end
				end
				default: ;
			endcase
		end
		if (txc_served_i) begin
			n.transmit_complete_flag = 1'b0;
		end
		// Transmitter: disabling only stops new loads, so a frame finishes.
		if (st.ctb[`UDS_B_TXEN] && !st.tx_busy && st.thr_full) begin
			n.tsr = uds_frame(st.thr, nb, pen, podd);
			n.tbits = nb + {3'h0, pen} + 4'h2 + {3'h0, stop2};
			n.tcnt = '0;
			n.tx_busy = 1'b1;
			n.thr_full = 1'b0;
		end else if (st.tx_busy && tick) begin
			if (st.tcnt == os - 5'd1) begin
				n.tcnt = '0;
				n.tsr = {1'b1, st.tsr[12:1]};
				n.tbits = st.tbits - 4'h1;
				if (st.tbits == 4'h1) begin
					n.tx_busy = 1'b0;
					if (!n.thr_full) begin
						n.transmit_complete_flag = 1'b1;
					end
				end
			end else begin
				n.tcnt = st.tcnt + 5'd1;
			end
		end
		n.txd = n.tx_busy ? n.tsr[0] : 1'b1;
		// A character parked in the shifter enters as soon as room appears.
		if (st.pend && n.cnt != DEPTH_C) begin
			n.fifo[n.wp] = st.pent;
			n.wp = n.wp + 1'b1;
			n.cnt = n.cnt + 1'b1;
			n.pend = 1'b0;
		end
		if (tick) begin
			case (st.rxs)
				uds_pkg::UDS_R_IDLE: begin
					if (!st.s2 && st.ctb[`UDS_B_RXEN]) begin
						if (n.pend && n.cnt == DEPTH_C) begin
							n.pent.overrun_flag = 1'b1;
						end else begin
							n.rxs = uds_pkg::UDS_R_START;
							n.rcnt = '0;
						end
					end
				end
				uds_pkg::UDS_R_START: begin
					if (st.rcnt == half - 5'd1) begin
						n.rcnt = '0;
						n.rbit = '0;
						n.rsh = '0;
						n.rxs = st.s2 ? uds_pkg::UDS_R_IDLE : uds_pkg::UDS_R_BITS;
					end else begin
						n.rcnt = st.rcnt + 5'd1;
					end
				end
				uds_pkg::UDS_R_BITS: begin
					if (st.rcnt == os - 5'd1) begin
						n.rcnt = '0;
						if (st.rbit < nb) begin
							n.rsh = {st.s2, st.rsh[8:1]};
						end else begin
							n.rpar = st.s2;
						end
						n.rbit = st.rbit + 4'h1;
						if (st.rbit == nb + {3'h0, pen} - 4'h1) begin
							n.rxs = uds_pkg::UDS_R_STOP;
						end
					end else begin
						n.rcnt = st.rcnt + 5'd1;
					end
				end
				uds_pkg::UDS_R_STOP: begin
					if (st.rcnt == os - 5'd1) begin
						n.rxs = uds_pkg::UDS_R_IDLE;
						ent.data = st.rsh >> (4'h9 - nb);
						ent.fe = ~st.s2;
						ent.pe = pen & (st.rpar ^ (^ent.data) ^ podd);
						// Address filter drops nine-bit frames whose ninth bit is clear.
						if (!(st.multiprocessor_filter_bit && nb == 4'h9 && !ent.data[8])) begin
							if (n.cnt != DEPTH_C) begin
								n.fifo[n.wp] = ent;
								n.wp = n.wp + 1'b1;
								n.cnt = n.cnt + 1'b1;
							end else begin
								n.pend = 1'b1;
								n.pent = ent;
							end
						end
					end else begin
						n.rcnt = st.rcnt + 5'd1;
					end
				end
				default: n.rxs = uds_pkg::UDS_R_IDLE;
			endcase
		end
		if (!n.ctb[`UDS_B_RXEN]) begin
			n.cnt = '0;
			n.rp = '0;
			n.wp = '0;
			n.pend = 1'b0;
			n.rxs = uds_pkg::UDS_R_IDLE;
		end
		n.rxc_q = n.ctb[`UDS_B_RXCIE] & global_ie_i & (n.cnt != '0);
		n.txc_q = n.ctb[`UDS_B_TXCIE] & global_ie_i & n.transmit_complete_flag;
		n.buffer_empty_flag_q = n.ctb[`UDS_B_BUFFER_EMPTY_IRQ_ENABLE] & global_ie_i & ~n.thr_full;
	end

	// State register; the line idles high so the synchroniser resets high.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st <= '0;
			st.ctb <= `UDS_CTB_RST;
			st.ctc <= `UDS_CTC_RST;
			st.txd <= 1'b1;
			st.s1 <= 1'b1;
			st.s2 <= 1'b1;
		end else begin
			st <= n;
		end
	end

	// Every output is a state bit.
	assign dat_o      = st.rdat;
	assign ack_o      = st.ack;
	assign txd_o      = st.txd;
	assign rxc_req_o  = st.rxc_q;
	assign txc_req_o  = st.txc_q;
	assign buffer_empty_flag_req_o = st.buffer_empty_flag_q;

	// ********************************
	// Checks
	// ********************************

	property p_reset_sta;
		@(posedge clk_i) disable iff (rst_i)
		$fell(rst_i) |-> uds_sta(st, head) == `UDS_STA_RST;
	endproperty
	a_reset_sta: assert property (p_reset_sta) else $error("status wrong after reset");

	property p_full_drop;
		@(posedge clk_i) disable iff (rst_i)
		(wr0 && idx == `UDS_IDX_DAT && st.thr_full) |=> $stable(st.thr);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("write to full buffer kept");

	property p_load;
		@(posedge clk_i) disable iff (rst_i)
		(st.ctb[`UDS_B_TXEN] && !st.tx_busy && st.thr_full) |=>
			(st.tx_busy && !st.txd && !st.thr_full);
	endproperty
	a_load: assert property (p_load) else $error("buffer not moved to shifter");

	property p_pop;
		@(posedge clk_i) disable iff (rst_i)
		(rd && idx == `UDS_IDX_DAT && st.cnt != '0 && st.ctb[`UDS_B_RXEN]) |=>
			st.rp != $past(st.rp);
	endproperty
	a_pop: assert property (p_pop) else $error("data read did not advance queue");

	property p_flush;
		@(posedge clk_i) disable iff (rst_i)
		!st.ctb[`UDS_B_RXEN] |-> (st.cnt == '0 && !st.pend);
	endproperty
	a_flush: assert property (p_flush) else $error("disabled receiver holds data");

	property p_served;
		@(posedge clk_i) disable iff (rst_i)
		(txc_served_i && !st.tx_busy) |=> !st.transmit_complete_flag;
	endproperty
	a_served: assert property (p_served) else $error("transmit-complete not cleared");

	property p_buffer_empty_flag_irq;
		@(posedge clk_i) disable iff (rst_i)
		st.buffer_empty_flag_q |-> (!st.thr_full && st.ctb[`UDS_B_BUFFER_EMPTY_IRQ_ENABLE] && $past(global_ie_i));
	endproperty
	a_buffer_empty_flag_irq: assert property (p_buffer_empty_flag_irq) else $error("empty request without cause");

	property p_spi_rsv;
		@(posedge clk_i) disable iff (rst_i)
		(rd && idx == `UDS_IDX_STA && st.ctc[`UDS_C_MODE] == `UDS_MODE_SPI) |=>
			(dat_o[`UDS_B_FE] == 1'b0 && dat_o[`UDS_B_DOR] == 1'b0);
	endproperty
	a_spi_rsv: assert property (p_spi_rsv) else $error("reserved bits set in SPI mode");

	property p_idle_line;
		@(posedge clk_i) disable iff (rst_i)
		!st.tx_busy |-> txd_o;
	endproperty
	a_idle_line: assert property (p_idle_line) else $error("line low while idle");
endmodule : uds_top
`default_nettype wire

/* File: test/uds_remote.sv */
`default_nettype none
// ********************
// Remote serial station
// ********************
module uds_remote (
	// Clock.
	input  wire logic clk_i,
	// Serial lines.
	input  wire logic from_dut_i,
	output logic      to_dut_o
);
	timeunit 1ns;
	timeprecision 100ps;
	int         bitlen = 16;
	logic [8:0] got[$];
	logic [8:0] b;

	// One frame, LSB first; pb[1] adds a parity bit of value pb[0].
	// A zero stop_v lets a scenario break the framing on purpose.
	task automatic send(input logic [7:0] d, input logic [1:0] pb, input logic stop_v);
		to_dut_o <= 1'b0;
		repeat (bitlen) @(posedge clk_i);
		for (int i = 0; i < 8; i++) begin
			to_dut_o <= d[i];
			repeat (bitlen) @(posedge clk_i);
		end
		if (pb[1]) begin
			to_dut_o <= pb[0];
			repeat (bitlen) @(posedge clk_i);
		end
		to_dut_o <= stop_v;
		repeat (bitlen) @(posedge clk_i);
		to_dut_o <= 1'b1;
		repeat (bitlen) @(posedge clk_i);
	endtask : send

	// Samples mid-bit; the stop level lands in bit 8 so framing is judged too.
	initial begin
		to_dut_o = 1'b1;
		forever begin
			@(negedge from_dut_i);
			repeat (bitlen / 2) @(posedge clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (bitlen) @(posedge clk_i);
				b[i] = from_dut_i;
			end
			got.push_back(b);
		end
	end
endmodule : uds_remote
`default_nettype wire

/* File: test/uds_top_tb.sv */
`include "uds_regs.svh"
`default_nettype none
// ********************
// Bench
// ********************
module uds_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [9:0] sta = `UDS_IDX_STA;
	localparam logic [9:0] ctb = `UDS_IDX_CTB;
	localparam logic [9:0] ctc = `UDS_IDX_CTC;
	localparam logic [9:0] dat = `UDS_IDX_DAT;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] rv;
	logic        ack;
	logic        rxd;
	logic        txd;
	logic        gie = 1'b0;
	logic        served = 1'b0;
	logic        rxc_req;
	logic        txc_req;
	logic        buffer_empty_flag_req;
	int          n_mismatch = 0;
	int          num_checks = 0;

	// Clock.
	always #2.5 clk = ~clk;

	uds_top dut_u (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.rxd_i(rxd), .txd_o(txd), .global_ie_i(gie), .txc_served_i(served),
		.rxc_req_o(rxc_req), .txc_req_o(txc_req), .buffer_empty_flag_req_o(buffer_empty_flag_req));
	uds_remote remote_u (.clk_i(clk), .from_dut_i(txd), .to_dut_o(rxd));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// Classic cycle: all held until ack is sampled high, then one idle cycle.
	task automatic bus(input logic [9:0] idx, input logic w, input logic [7:0] d);
		int t = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
			t++;
		end while (ack !== 1'b1 && t < 40);
		rv = rdat;
		if (ack !== 1'b1) begin
			n_mismatch++;
			finish_test();
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rdc(input logic [9:0] idx, input logic [7:0] exp);
		bus(idx, 1'b0, 8'h00);
		check(rv, {24'h0, exp});
	endtask : rdc

	// Polls status with a bounded count; running out shows as a mismatch.
	task automatic wait_sta(input logic [7:0] exp);
		int t = 0;
		do begin
			bus(sta, 1'b0, 8'h00);
			t++;
		end while (rv !== {24'h0, exp} && t < 400);
		check(rv, {24'h0, exp});
	endtask : wait_sta

	task automatic t_reset;
		rdc(sta, 8'h20);
		rdc(dat, 8'h00);
		rdc(10'h0c3, 8'h00);
		check(buffer_empty_flag_req, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_irq;
		bus(ctb, 1'b1, 8'h28);
		repeat (3) @(posedge clk);
		check(buffer_empty_flag_req, 1'b0);
		gie <= 1'b1;
		repeat (3) @(posedge clk);
		check(buffer_empty_flag_req, 1'b1);
		bus(ctb, 1'b1, 8'h08);
		repeat (2) @(posedge clk);
		check(buffer_empty_flag_req, 1'b0);
		$display("test irq done");
	endtask : t_irq

	task automatic t_tx;
		remote_u.got.delete();
		bus(ctb, 1'b1, 8'h48);
		bus(dat, 1'b1, 8'ha5);
		bus(dat, 1'b1, 8'h3c);
		rdc(sta, 8'h00);
		// Buffer is still full here, so this byte must vanish.
		bus(dat, 1'b1, 8'h77);
		wait_sta(8'h60);
		check(txc_req, 1'b1);
		check(remote_u.got.size(), 2);
		check(remote_u.got[0], 9'h1a5);
		check(remote_u.got[1], 9'h13c);
		served <= 1'b1;
		@(posedge clk);
		served <= 1'b0;
		repeat (2) @(posedge clk);
		check(txc_req, 1'b0);
		bus(dat, 1'b1, 8'h5e);
		wait_sta(8'h60);
		bus(sta, 1'b1, 8'h40);
		rdc(sta, 8'h20);
		$display("test tx done");
	endtask : t_tx

	// Data location is only ever read singly, never modified in place.
	task automatic t_rx;
		bus(ctb, 1'b1, 8'h90);
		remote_u.send(8'h11, 2'b00, 1'b0);
		remote_u.send(8'h22, 2'b00, 1'b1);
		remote_u.send(8'h33, 2'b00, 1'b1);
		remote_u.send(8'hff, 2'b00, 1'b1);
		check(rxc_req, 1'b1);
		rdc(sta, 8'hb0);
		bus(ctc, 1'b1, 8'hc6);
		rdc(sta, 8'ha0);
		bus(ctc, 1'b1, 8'h06);
		rdc(dat, 8'h11);
		rdc(sta, 8'ha0);
		rdc(dat, 8'h22);
		rdc(sta, 8'ha8);
		rdc(dat, 8'h33);
		rdc(sta, 8'h20);
		$display("test rx done");
	endtask : t_rx

	task automatic t_fmt;
		bus(ctc, 1'b1, 8'h04);
		remote_u.send(8'hff, 2'b00, 1'b1);
		rdc(dat, 8'h7f);
		bus(ctc, 1'b1, 8'h26);
		remote_u.send(8'h01, 2'b10, 1'b1);
		rdc(sta, 8'ha4);
		rdc(dat, 8'h01);
		bus(ctc, 1'b1, 8'h06);
		remote_u.send(8'h5a, 2'b00, 1'b1);
		rdc(sta, 8'ha0);
		bus(ctb, 1'b1, 8'h00);
		rdc(sta, 8'h20);
		$display("test format done");
	endtask : t_fmt

	// Nine-bit characters: the ninth bit is fetched before the low byte.
	task automatic t_nine;
		bus(ctb, 1'b1, 8'h14);
		remote_u.send(8'h5a, 2'b11, 1'b1);
		rdc(ctb, 8'h16);
		rdc(dat, 8'h5a);
		// With the filter on, a frame whose ninth bit is clear never queues.
		bus(sta, 1'b1, 8'h01);
		remote_u.send(8'h33, 2'b10, 1'b1);
		remote_u.send(8'h44, 2'b11, 1'b1);
		rdc(sta, 8'ha1);
		rdc(ctb, 8'h16);
		rdc(dat, 8'h44);
		bus(sta, 1'b1, 8'h00);
		bus(ctb, 1'b1, 8'h00);
		$display("test nine done");
	endtask : t_nine

	task automatic t_fast;
		remote_u.got.delete();
		remote_u.bitlen = 8;
		bus(sta, 1'b1, 8'h02);
		bus(ctb, 1'b1, 8'h08);
		bus(dat, 1'b1, 8'hc3);
		wait_sta(8'h62);
		check(remote_u.got[0], 9'h1c3);
		$display("test fast done");
	endtask : t_fast

	// Main sequence.
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_irq();
		t_tx();
		t_rx();
		t_fmt();
		t_nine();
		t_fast();
		finish_test();
	end
endmodule : uds_top_tb
`default_nettype wire
